// ### verilog/regulator_fault_supervisor.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps

module rfsv_debounce #(
    parameter int RISE = 1,
    parameter int FALL = 1
) (
    input  wire logic clk,   // 40 MHz clock
    input  wire logic reset, // Async reset, high
    input  wire logic din,   // Synchronised level
    output logic      dout   // Filtered level
);
    import rfsv_pkg::*;

    typedef struct packed {
        logic             level;
        logic [CNT_W-1:0] cnt;
    } rfsv_deb_state_t;

    rfsv_deb_state_t s_q, s_d;

    // Window lengths must fit the counter
    if (RISE < 1 || FALL < 1 || RISE > 2**CNT_W || FALL > 2**CNT_W) begin : gBadLength
        $error("debounce length out of range");
    end

    // Level must differ for a full window before it is taken
    always_comb begin
        s_d = s_q;
        if (din == s_q.level) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == (din ? CNT_W'(RISE - 1) : CNT_W'(FALL - 1))) begin
            s_d.level = din;
            s_d.cnt   = '0;
        end else begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.level;
endmodule : rfsv_debounce

module regulator_fault_supervisor #(
    parameter int FAULT_CYC_P = rfsv_pkg::FAULT_CYC // Short / overload window
) (
    input  wire logic                     clk,             // 40 MHz clock
    input  wire logic                     reset,           // Async reset, high
    input  wire rfsv_pkg::rfsv_apb_req_t  apbReq,          // APB request
    output rfsv_pkg::rfsv_apb_rsp_t       apbRsp,          // APB answer
    input  wire rfsv_pkg::rfsv_sense_t    sense,           // Raw comparators, pins
    output rfsv_pkg::rfsv_reg_pins_t      regPins,         // Regulator stage control
    output logic                          irq_n,           // Interrupt, active low
    output logic [1:0]                    genOut,          // Outputs a, b: level
    output logic [1:0]                    genOe,           // Outputs a, b: enable
    output logic                          extSyncClockIn,  // Sampled clock pin
    output rfsv_pkg::rfsv_mode_t          mode             // Operating mode
);
    import rfsv_pkg::*;

    typedef struct packed {
        rfsv_sense_t                 sync1;
        rfsv_sense_t                 sync2;
        rfsv_mode_t                  mode;
        logic                        warnSel;
        logic                        auxSel;
        logic [3:0]                  regEn;
        logic [3:0]                  disEn;
        logic [5:0]                  outCtrl;
        logic                        warnFlag;
        logic                        tsdFlag;
        logic                        ovpFlag;
        logic                        rstFlag;
        logic [3:0]                  shortFlag;
        logic [7:0]                  mask;
        logic [3:0]                  regOn;
        logic [3:0]                  running;
        logic [NREG-1:0][CNT_W-1:0]  cnt;
        logic                        warnPrev;
        logic [7:0]                  tick;
        logic                        enSampled;
        logic [1:0]                  gOut;
        logic [1:0]                  gOe;
        logic                        irqN;
        logic [31:0]                 rdata;
    } rfsv_state_t;

    rfsv_state_t s_q, s_d;
    logic        warnSt, warnLoF, warnHiF, tsdSt, ovpSt;
    logic        blocked, hostOk, setup, access, mapped, wr, forceLow, val;
    logic [7:0]  flagVec;

    // Window must fit the counter, tick must fit eight bits
    if (FAULT_CYC_P < 2 || FAULT_CYC_P > 2**CNT_W || SYNC_CYC > 256) begin : gBadWindow
        $error("fault window out of range");
    end

    // ************************************************************
    // Filters
    // ************************************************************
    rfsv_debounce #(.RISE(THERM_CYC), .FALL(THERM_CYC)) uWarnLo (
        .clk(clk), .reset(reset), .din(s_q.sync2.warnLo), .dout(warnLoF));
    rfsv_debounce #(.RISE(THERM_CYC), .FALL(THERM_CYC)) uWarnHi (
        .clk(clk), .reset(reset), .din(s_q.sync2.warnHi), .dout(warnHiF));
    rfsv_debounce #(.RISE(THERM_CYC), .FALL(THERM_CYC)) uTsd (
        .clk(clk), .reset(reset), .din(s_q.sync2.tsd), .dout(tsdSt));
    rfsv_debounce #(.RISE(OVP_RISE_CYC), .FALL(OVP_FALL_CYC)) uOvp (
        .clk(clk), .reset(reset), .din(s_q.sync2.ovp), .dout(ovpSt));

    // Warning threshold picked by configuration
    assign warnSt = s_q.warnSel ? warnHiF : warnLoF;

    // ************************************************************
    // Bus decode
    // ************************************************************
    assign setup  = apbReq.psel & ~apbReq.penable;
    assign access = apbReq.psel & apbReq.penable;
    assign mapped = apbReq.paddr inside {OFS_CONFIG, OFS_REG_CTRL, OFS_OUT_CTRL,
                                         OFS_FLAGS, OFS_SHORT, OFS_MASK, OFS_STATUS};
    // Register writes only open once settings are loaded
    assign hostOk = (s_q.mode == MODE_STANDBY) || (s_q.mode == MODE_ACTIVE);
    assign wr     = access & apbReq.pwrite & mapped & hostOk;
    assign flagVec = {s_q.shortFlag, s_q.rstFlag, s_q.ovpFlag, s_q.tsdFlag, s_q.warnFlag};

    // Any pending overvoltage or thermal-shutdown flag keeps every regulator off
    assign blocked = ovpSt | s_q.ovpFlag | tsdSt | s_q.tsdFlag | ~hostOk;
    assign forceLow = ovpSt | s_q.ovpFlag;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d       = s_q;
        val       = 1'b0;
        s_d.sync1 = sense;
        s_d.sync2 = s_q.sync1;
        s_d.tick  = (s_q.tick == 8'(SYNC_CYC - 1)) ? 8'h00 : s_q.tick + 8'h01;
        // Enable pin is only resampled, never filtered
        if (s_q.tick == 8'h00) begin
            s_d.enSampled = s_q.sync2.enPin;
        end

        // Host writes; set terms below override these clears
        if (wr) begin
            case (apbReq.paddr)
                OFS_CONFIG: begin
                    s_d.warnSel = apbReq.pwdata[CFG_WARN_SEL];
                    s_d.auxSel  = apbReq.pwdata[CFG_AUX_SEL];
                end
                OFS_REG_CTRL: begin
                    s_d.regEn = apbReq.pwdata[3:0];
                    s_d.disEn = apbReq.pwdata[RC_DIS_LO +: 4];
                end
                OFS_OUT_CTRL: s_d.outCtrl = apbReq.pwdata[5:0];
                OFS_FLAGS: begin
                    s_d.warnFlag = s_q.warnFlag & ~apbReq.pwdata[FLG_WARN];
                    s_d.tsdFlag  = s_q.tsdFlag & ~apbReq.pwdata[FLG_TSD];
                    s_d.ovpFlag  = s_q.ovpFlag & ~apbReq.pwdata[FLG_OVP];
                    s_d.rstFlag  = s_q.rstFlag & ~apbReq.pwdata[FLG_RST];
                end
                OFS_SHORT: s_d.shortFlag = s_q.shortFlag & ~apbReq.pwdata[3:0];
                OFS_MASK:  s_d.mask = apbReq.pwdata[7:0];
                default: ;
            endcase
        end

        // Event flags, set wins over a same-cycle clear
        s_d.warnPrev = warnSt;
        if (warnSt && !s_q.warnPrev) begin
            s_d.warnFlag = 1'b1;
        end
        if (tsdSt) begin
            s_d.tsdFlag = 1'b1;
        end
        if (ovpSt) begin
            s_d.ovpFlag = 1'b1;
        end

        // Per-regulator start-up and overload timing
        for (int i = 0; i < NREG; i++) begin
            s_d.regOn[i] = s_q.regEn[i] & ~s_d.shortFlag[i] & ~blocked;
            if (!s_d.regOn[i]) begin
                s_d.cnt[i]     = '0;
                s_d.running[i] = 1'b0;
            end else if (s_q.cnt[i] == CNT_W'(FAULT_CYC_P - 1)) begin
                s_d.cnt[i] = '0;
                if (s_q.sync2.below[i]) begin
                    s_d.shortFlag[i] = 1'b1;
                    s_d.running[i]   = 1'b0;
                    s_d.regOn[i]     = 1'b0;
                end else begin
                    s_d.running[i] = 1'b1;
                end
            end else if (!s_q.running[i] || s_q.sync2.below[i]) begin
                s_d.cnt[i] = s_q.cnt[i] + CNT_W'(1);
            end else begin
                s_d.cnt[i] = '0;
            end
        end

        // Mode sequencing
        case (s_q.mode)
            MODE_SHUTDOWN: begin
                if (s_q.tick == 8'h00 && !s_q.sync2.uvlo) begin
                    s_d.mode = MODE_READ_OTP;
                end
            end
            MODE_READ_OTP: begin
                s_d.mode    = MODE_STANDBY;
                s_d.rstFlag = ~s_q.mask[FLG_RST];
            end
            MODE_STANDBY, MODE_ACTIVE: begin
                s_d.mode = (|s_d.regOn) ? MODE_ACTIVE : MODE_STANDBY;
                if (wr && apbReq.paddr == OFS_CONFIG && apbReq.pwdata[CFG_SWRST]) begin
                    s_d.mode = MODE_READ_OTP;
                end
            end
            default: s_d.mode = MODE_SHUTDOWN;
        endcase

        // Defaults reloaded on shutdown and software reset
        if (s_d.mode != s_q.mode && s_d.mode == MODE_READ_OTP || s_q.sync2.uvlo) begin
            s_d.warnSel   = 1'b0;
            s_d.auxSel    = 1'b0;
            s_d.regEn     = '0;
            s_d.disEn     = RST_DIS_EN;
            s_d.outCtrl   = RST_OUT_CTRL;
            s_d.mask      = RST_MASK;
            s_d.warnFlag  = 1'b0;
            s_d.tsdFlag   = 1'b0;
            s_d.ovpFlag   = 1'b0;
            s_d.shortFlag = '0;
        end
        // Falling supply acts at once, no filter
        if (s_q.sync2.uvlo) begin
            s_d.mode    = MODE_SHUTDOWN;
            s_d.regOn   = '0;
            s_d.running = '0;
            s_d.cnt     = '0;
            s_d.rstFlag = 1'b0;
        end

        // General outputs: overvoltage overrides the level
        for (int g = 0; g < 2; g++) begin
            val = ~forceLow & s_d.outCtrl[g*OC_STRIDE + OC_LVL]
                  & (~s_d.outCtrl[g*OC_STRIDE + OC_SEQ] | s_d.enSampled);
            if (s_d.outCtrl[g*OC_STRIDE + OC_OD]) begin
                s_d.gOut[g] = 1'b0;
                s_d.gOe[g]  = ~val;
            end else begin
                s_d.gOut[g] = val;
                s_d.gOe[g]  = 1'b1;
            end
        end
        // Pin b becomes a clock input when selected
        if (s_d.auxSel) begin
            s_d.gOut[1] = 1'b0;
            s_d.gOe[1]  = 1'b0;
        end

        // Interrupt line tracks unmasked flags
        s_d.irqN = ~|({s_d.shortFlag, s_d.rstFlag, s_d.ovpFlag, s_d.tsdFlag, s_d.warnFlag}
                      & ~s_d.mask);

        // Read data captured in setup so it comes from a flop
        if (setup) begin
            s_d.rdata = 32'h0000_0000;
            case (apbReq.paddr)
                OFS_CONFIG:   s_d.rdata[1:0] = {s_q.auxSel, s_q.warnSel};
                OFS_REG_CTRL: s_d.rdata[7:0] = {s_q.disEn, s_q.regEn};
                OFS_OUT_CTRL: s_d.rdata[5:0] = s_q.outCtrl;
                OFS_FLAGS:    s_d.rdata[7:0] = {s_q.shortFlag, s_q.rstFlag, s_q.ovpFlag,
                                                s_q.tsdFlag, s_q.warnFlag};
                OFS_SHORT:    s_d.rdata[3:0] = s_q.shortFlag;
                OFS_MASK:     s_d.rdata[7:0] = s_q.mask;
                OFS_STATUS: begin
                    s_d.rdata[2:0]             = {ovpSt, tsdSt, warnSt};
                    s_d.rdata[ST_RUN_LO +: 4]  = s_q.running;
                    s_d.rdata[ST_MODE_LO +: 2] = s_q.mode;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q      <= '0;
            s_q.irqN <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Off stage is high-Z; pulldown only if allowed
    assign regPins.drive     = s_q.regOn;
    assign regPins.highZ     = ~s_q.regOn;
    assign regPins.discharge = ~s_q.regOn & s_q.disEn;
    assign irq_n             = s_q.irqN;
    assign genOut            = s_q.gOut;
    assign genOe             = s_q.gOe;
    assign extSyncClockIn    = s_q.auxSel & s_q.sync2.auxPin;
    assign mode              = s_q.mode;
    assign apbRsp.prdata     = s_q.rdata;
    assign apbRsp.pready     = 1'b1;
    assign apbRsp.pslverr    = access & ~mapped;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence seqOvpEntry;
        !ovpSt ##1 ovpSt;
    endsequence

    AST_IRQ_TRACKS: assert property (@(posedge clk) disable iff (reset)
        s_q.irqN == !(|(flagVec & ~s_q.mask))) else $error("irq line wrong");
    AST_WARN_SET: assert property (@(posedge clk) disable iff (reset)
        (hostOk && warnSt && !s_q.warnPrev && !s_q.sync2.uvlo) |=> s_q.warnFlag)
        else $error("warning flag not set");
    AST_OVP_ENTRY: assert property (@(posedge clk) disable iff (reset)
        seqOvpEntry |=> (s_q.regOn == 4'h0 && s_q.running == 4'h0 && s_q.ovpFlag))
        else $error("overvoltage did not disable");
    AST_OVP_OUT_LOW: assert property (@(posedge clk) disable iff (reset)
        ovpSt |=> (s_q.gOut == 2'b00)) else $error("output not forced low");
    AST_OVP_HOLD: assert property (@(posedge clk) disable iff (reset)
        (s_q.ovpFlag && ovpSt && !s_q.sync2.uvlo) |=> s_q.ovpFlag)
        else $error("overvoltage flag cleared early");
    AST_TSD_HOLD: assert property (@(posedge clk) disable iff (reset)
        (s_q.tsdFlag && tsdSt && !s_q.sync2.uvlo) |=> (s_q.tsdFlag && s_q.regOn == 4'h0))
        else $error("thermal flag cleared early");
    AST_SHORT_TRIP: assert property (@(posedge clk) disable iff (reset)
        (s_q.regOn[0] && s_q.cnt[0] == CNT_W'(FAULT_CYC_P - 1) && s_q.sync2.below[0]
         && !s_q.sync2.uvlo) |=> (s_q.shortFlag[0] && !s_q.regOn[0] && !s_q.running[0]))
        else $error("short not tripped");
    AST_LINEAR_TRIP: assert property (@(posedge clk) disable iff (reset)
        $rose(s_q.shortFlag[2]) |-> (!s_q.running[2] && !s_q.regOn[2]))
        else $error("linear fault left running");
    AST_UVLO_OFF: assert property (@(posedge clk) disable iff (reset)
        s_q.sync2.uvlo |=> (s_q.mode == MODE_SHUTDOWN && s_q.regOn == 4'h0))
        else $error("undervoltage not honoured");
    AST_RESET_FLAG: assert property (@(posedge clk) disable iff (reset)
        (s_q.mode == MODE_READ_OTP && !s_q.mask[FLG_RST] && !s_q.sync2.uvlo)
        |=> (s_q.mode == MODE_STANDBY && s_q.rstFlag)) else $error("reset flag missing");
endmodule : regulator_fault_supervisor

// ### verilog/rfsv_pkg.sv
package rfsv_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ       = 40;        // 25 ns period
    localparam int T_FAULT_NS    = 1_000_000; // Short / overload window, 1 ms
    localparam int T_THERM_NS    = 20_000;    // Thermal filters, 20 us
    localparam int T_OVP_RISE_NS = 1_000;     // Overvoltage detect, 1 us
    localparam int T_OVP_FALL_NS = 20_000;    // Overvoltage release, 20 us
    localparam int T_SYNC_NS     = 3_000;     // Enable / recovery sampling, 3 us

    // Least time, rounded up to whole cycles
    function automatic int rfsvCycles(input int ns);
        return (ns * CLK_MHZ + 999) / 1000;
    endfunction : rfsvCycles

    localparam int FAULT_CYC    = rfsvCycles(T_FAULT_NS);
    localparam int THERM_CYC    = rfsvCycles(T_THERM_NS);
    localparam int OVP_RISE_CYC = rfsvCycles(T_OVP_RISE_NS);
    localparam int OVP_FALL_CYC = rfsvCycles(T_OVP_FALL_NS);
    localparam int SYNC_CYC     = rfsvCycles(T_SYNC_NS);
    localparam int CNT_W        = 17;
    localparam int NREG         = 4;          // 0,1 switchers; 2,3 linears

    // ************************************************************
    // Register map and fields
    // ************************************************************
    localparam logic [7:0] OFS_CONFIG   = 8'h00;
    localparam logic [7:0] OFS_REG_CTRL = 8'h04;
    localparam logic [7:0] OFS_OUT_CTRL = 8'h08;
    localparam logic [7:0] OFS_FLAGS    = 8'h0c;
    localparam logic [7:0] OFS_SHORT    = 8'h10;
    localparam logic [7:0] OFS_MASK     = 8'h14;
    localparam logic [7:0] OFS_STATUS   = 8'h18;

    localparam int CFG_WARN_SEL = 0;
    localparam int CFG_AUX_SEL  = 1;
    localparam int CFG_SWRST    = 2;
    localparam int RC_DIS_LO    = 4;
    localparam int OC_OD        = 0;
    localparam int OC_LVL       = 1;
    localparam int OC_SEQ       = 2;
    localparam int OC_STRIDE    = 3;
    localparam int FLG_WARN     = 0;
    localparam int FLG_TSD      = 1;
    localparam int FLG_OVP      = 2;
    localparam int FLG_RST      = 3;
    localparam int FLG_SUM_LO   = 4;
    localparam int ST_RUN_LO    = 4;
    localparam int ST_MODE_LO   = 8;

    localparam logic [3:0] RST_DIS_EN   = 4'hf;
    localparam logic [5:0] RST_OUT_CTRL = 6'h00;
    localparam logic [7:0] RST_MASK     = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {MODE_SHUTDOWN, MODE_READ_OTP, MODE_STANDBY, MODE_ACTIVE} rfsv_mode_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } rfsv_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rfsv_apb_rsp_t;

    typedef struct packed {
        logic       auxPin;
        logic       enPin;
        logic       warnHi;
        logic       warnLo;
        logic       tsd;
        logic       ovp;
        logic       uvlo;
        logic [3:0] below;
    } rfsv_sense_t;

    typedef struct packed {
        logic [3:0] drive;
        logic [3:0] highZ;
        logic [3:0] discharge;
    } rfsv_reg_pins_t;

endpackage : rfsv_pkg

// ### verification/rfsv_host.sv
`timescale 1ns/1ps

// ************************************************************
// Host processor model: APB master
// ************************************************************
module rfsv_host (
    input  wire logic                    clk,    // 40 MHz clock
    output rfsv_pkg::rfsv_apb_req_t      apbReq, // Request to the device
    input  wire rfsv_pkg::rfsv_apb_rsp_t apbRsp  // Answer from the device
);
    import rfsv_pkg::*;

    logic slvErr; // Error answer of the last transfer

    // Bus idle from time zero
    initial apbReq = '0;

    // Setup, then access held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do @(posedge clk); while (apbRsp.pready !== 1'b1);
        rdata = apbRsp.prdata;
        slvErr = apbRsp.pslverr;
        apbReq <= '0;
    endtask : xfer

    // Flags are cleared by writing ones, or by shutdown; software reset clears all but the reset flag, which it sets again
    task automatic clear(input logic [7:0] addr, input logic [31:0] bits);
        logic [31:0] unused;
        xfer(1'b1, addr, bits, unused);
    endtask : clear
endmodule : rfsv_host

// ### verification/regulator_fault_supervisor_bench.sv
`timescale 1ns/1ps

module regulator_fault_supervisor_bench;
    import rfsv_pkg::*;
    localparam int FC = 20; // Short window kept small for run time
    logic           clk, reset, irq_n, extSyncClockIn;
    rfsv_apb_req_t  apbReq;
    rfsv_apb_rsp_t  apbRsp;
    rfsv_sense_t    sense;
    rfsv_reg_pins_t regPins;
    logic [1:0]     genOut, genOe;
    rfsv_mode_t     mode;
    logic [31:0]    rd;
    int             mismatches, n_compared;

    regulator_fault_supervisor #(.FAULT_CYC_P(FC)) u_regulator_fault_supervisor (
        .clk(clk), .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp), .sense(sense),
        .regPins(regPins), .irq_n(irq_n), .genOut(genOut), .genOe(genOe),
        .extSyncClockIn(extSyncClockIn), .mode(mode));
    rfsv_host u_rfsv_host (.clk(clk), .apbReq(apbReq), .apbRsp(apbRsp));

    // ************************************************************
    // Helpers
    // ************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk
    task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
        u_rfsv_host.xfer(1'b0, a, 32'h0, rd);
        chk(rd & m, e, s);
    endtask : rdchk
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_rfsv_host.xfer(1'b1, a, d, rd);
    endtask : wr
    // Lets the edge's own updates settle before looking
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task stby;
        // Recovery waits for the next sampling tick, so allow two tick periods
        for (int i = 0; i < 2 * SYNC_CYC && mode !== MODE_STANDBY; i++) @(posedge clk);
    endtask : stby
    task results;
        if (mismatches == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_reset;
        stby();
        chk(mode, MODE_STANDBY, "not standby after reset");
        rdchk(OFS_FLAGS, 32'h8, 32'h8, "reset flag");
        chk(irq_n, 1'b0, "irq after reset");
        rdchk(OFS_REG_CTRL, 32'hff, 32'hf0, "reg ctrl default");
        chk(u_rfsv_host.slvErr, 1'b0, "error on mapped read");
        rdchk(8'h1c, 32'hffffffff, 32'h0, "unmapped read");
        chk(u_rfsv_host.slvErr, 1'b1, "no error on unmapped read");
        u_rfsv_host.clear(OFS_FLAGS, 32'h8);
        wt(2);
        chk(irq_n, 1'b1, "irq stuck after clear");
    endtask : t_reset

    // Short at start, restart on clear, then overload while running
    task t_short(input int k);
        logic [3:0] b;
        b = 4'h1 << k;
        sense.below <= b;
        wr(OFS_REG_CTRL, (k == 3) ? 32'h70 | b : 32'hf0 | b);
        wt(FC + 10);
        rdchk(OFS_SHORT, 32'hf, b, "short flag");
        rdchk(OFS_FLAGS, 32'hf0, {b, 4'h0}, "summary flag");
        rdchk(OFS_STATUS, 32'hf0, 32'h0, "running not cleared");
        chk(irq_n, 1'b0, "irq on short");
        chk(regPins.highZ[k], 1'b1, "stage not high-Z");
        chk(regPins.discharge[k], k != 3, "discharge pulldown");
        sense.below <= 4'h0;
        u_rfsv_host.clear(OFS_SHORT, b);
        wt(FC + 10);
        rdchk(OFS_STATUS, 32'hf0, {b, 4'h0}, "no restart");
        chk(irq_n, 1'b1, "irq after short clear");
        sense.below <= b;
        wt(FC + 10);
        rdchk(OFS_SHORT, 32'hf, b, "overload not caught");
        sense.below <= 4'h0;
        wr(OFS_REG_CTRL, 32'hf0);
        u_rfsv_host.clear(OFS_SHORT, b);
    endtask : t_short

    task t_ovp;
        wr(OFS_OUT_CTRL, 32'h2);
        wr(OFS_REG_CTRL, 32'hf1);
        wt(FC + 10);
        chk(genOut[0] & genOe[0], 1'b1, "push-pull high");
        @(posedge clk) sense.ovp <= 1'b1;
        wt(50);
        chk(regPins.drive, 4'h0, "regulators on in overvoltage");
        chk(genOut, 2'b00, "outputs not low");
        chk(irq_n, 1'b0, "irq on overvoltage");
        rdchk(OFS_STATUS, 32'hf4, 32'h4, "running or status");
        u_rfsv_host.clear(OFS_FLAGS, 32'h4);
        rdchk(OFS_FLAGS, 32'h4, 32'h4, "flag cleared while high");
        sense.ovp <= 1'b0;
        wt(850);
        u_rfsv_host.clear(OFS_FLAGS, 32'h4);
        wt(FC + 10);
        rdchk(OFS_STATUS, 32'hf0, 32'h10, "no start after release");
        wr(OFS_REG_CTRL, 32'hf0);
        wr(OFS_OUT_CTRL, 32'h1);
        wt(2);
        chk({genOut[0], genOe[0]}, 2'b01, "open drain low");
        wr(OFS_OUT_CTRL, 32'h3);
        wt(2);
        chk({genOut[0], genOe[0]}, 2'b00, "open drain released");
        // Output a tied to the enable pin, output b plain high
        wr(OFS_OUT_CTRL, 32'h16);
        wt(2);
        chk(genOut, 2'b10, "sequence link ignored");
        @(posedge clk) sense.enPin <= 1'b1;
        wt(SYNC_CYC + 5);
        chk(genOut, 2'b11, "enable pin not followed");
    endtask : t_ovp

    task t_therm;
        @(posedge clk) sense.warnLo <= 1'b1;
        wt(810);
        rdchk(OFS_FLAGS, 32'h1, 32'h1, "warning flag");
        chk(irq_n, 1'b0, "irq on warning");
        rdchk(OFS_STATUS, 32'h1, 32'h1, "warning status");
        u_rfsv_host.clear(OFS_FLAGS, 32'h1);
        rdchk(OFS_FLAGS, 32'h1, 32'h0, "warning clear");
        wr(OFS_CONFIG, 32'h1);
        rdchk(OFS_STATUS, 32'h1, 32'h0, "threshold select ignored");
        wr(OFS_CONFIG, 32'h0);
        sense.warnLo <= 1'b0;
        wt(810);
        wr(OFS_MASK, 32'h1);
        sense.warnLo <= 1'b1;
        wt(810);
        chk(irq_n, 1'b1, "masked warning on irq");
        wr(OFS_REG_CTRL, 32'hf1);
        wt(2);
        chk(mode, MODE_ACTIVE, "not active with regulator on");
        @(posedge clk) sense.tsd <= 1'b1;
        wt(810);
        rdchk(OFS_FLAGS, 32'h2, 32'h2, "shutdown flag");
        chk(mode, MODE_STANDBY, "mode on shutdown");
        chk(regPins.drive, 4'h0, "regulator on when hot");
        u_rfsv_host.clear(OFS_FLAGS, 32'h2);
        rdchk(OFS_FLAGS, 32'h2, 32'h2, "shutdown flag cleared while hot");
        sense.tsd <= 1'b0;
        wt(810);
    endtask : t_therm

    task t_aux;
        wr(OFS_CONFIG, 32'h2);
        sense.auxPin <= 1'b1;
        wt(4);
        chk(extSyncClockIn, 1'b1, "clock input routing");
        chk(genOe[1], 1'b0, "pin b still driven as output");
        wr(OFS_CONFIG, 32'h0);
        wt(2);
        chk(extSyncClockIn, 1'b0, "output routing");
        @(posedge clk) sense.uvlo <= 1'b1;
        wt(4);
        chk(mode, MODE_SHUTDOWN, "undervoltage mode");
        @(posedge clk) sense.uvlo <= 1'b0;
        stby();
        chk(mode, MODE_STANDBY, "no standby after recovery");
        rdchk(OFS_FLAGS, 32'h8, 32'h8, "reset flag after recovery");
    endtask : t_aux

    // ************************************************************
    // Clock, reset, sequence, watchdog
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        reset = 1'b1;
        sense = '0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        for (int k = 0; k < NREG; k++) t_short(k);
        t_ovp();
        t_therm();
        t_aux();
        results();
    end
    // Longest expected run is under 8000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        results();
    end
endmodule : regulator_fault_supervisor_bench
